// *** src/rpm_pkg.sv ***
// package: constants and types for the receiver operating-mode state machine
package rpm_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ     = 20_000_000;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int EN_FILTER_US    = 10;        // receive-enable filter time
  localparam int EN_FILTER_CYC   = (EN_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_LINK_HZ     = 500_000;   // below this the link clock counts as stopped
  localparam int LINK_IDLE_CYC   = CLK_FREQ_HZ / MIN_LINK_HZ;
  // defaults for the times that carry no printed figure
  localparam int WAKEUP_CYC_DEF  = 400;
  localparam int SLEEP_CYC_DEF   = 4;
  localparam int PWRDN_CYC_DEF   = 200;
  localparam int CNT_W           = 12;
  // ---------------------------------------------------------------
  // data word layout and static pattern
  // ---------------------------------------------------------------
  localparam int WORD_W          = 27;
  localparam int PIX_W           = 24;
  localparam int VSYNC_BIT       = 26;
  localparam int HSYNC_BIT       = 25;
  localparam int DEN_BIT         = 24;
  localparam logic [PIX_W-1:0] STATIC_PIX   = 24'hffffff;
  localparam logic             STATIC_SYNC  = 1'b1;
  localparam logic             STATIC_LOW   = 1'b0;
  localparam int FIFO_DEPTH      = 4;
  // ---------------------------------------------------------------
  // link-select encoding and lane enables
  // ---------------------------------------------------------------
  localparam logic [1:0] LS_ONE   = 2'h0;
  localparam logic [1:0] LS_TWO   = 2'h1;
  localparam logic [1:0] LS_THREE = 2'h2;
  localparam logic [2:0] LANES_ONE   = 3'h1;
  localparam logic [2:0] LANES_TWO   = 3'h3;
  localparam logic [2:0] LANES_THREE = 3'h7;
  localparam logic [2:0] LANES_NONE  = 3'h0;
  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RPM_SHUTDOWN = 2'b00,
    RPM_STANDBY  = 2'b01,
    RPM_ACQUIRE  = 2'b10,
    RPM_RECEIVE  = 2'b11
  } rpm_mode_t;
endpackage : rpm_pkg

// *** src/rpm_receiver_power_mode_fsm.sv ***
// file: word fifo and operating-mode state machine of the video receiver
// Operation
// R1: enable low over 10 us enters shutdown
// R2: enable high 10 us, link idle: standby
// R3: standby keeps monitor only, pll off
// R4: shutdown to standby turns monitor on
// R5: link activity and valid level wake acquire
// R6: acquire enables pll, outputs stay static
// R7: lock within wakeup enters receive, held while locked
// R8: receive enables only selected lanes
// R9: outputs switch at first recovered word
// R10: transmitter stops clock to request standby
// R11: raised common mode leaves receive within sleep
// R12: static pattern at next pixel clock fall; code restores it at once on leaving receive
// R13: after exit pll off, monitor on
// R14: enable low past power-down time: shutdown
// R15: enable input sampled even in shutdown
// R16: link clock under 500 kHz means standby
// R17: link select 00/01/10 lanes 1/2/3, 11 reserved
// R18: wakeup, sleep, power-down are cycle parameters
`timescale 1ns/10ps

// ---------------------------------------------------------------
// small synchronous fifo with registered ready
// ---------------------------------------------------------------
module rpm_word_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             ready_r;
  wire              push = in_valid_i & ready_r & ~flush_i;
  wire              pop  = out_valid_o & out_ready_i & ~flush_i;

  // occupancy bookkeeping; ready stays a flop so back-pressure is honest
  always_comb begin
    count_nxt = count_r;
    if (flush_i) begin
      count_nxt = '0;
    end else if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b0;
    end else begin
      count_r  <= count_nxt;
      ready_r  <= (count_nxt < (AW+1)'(DEPTH));
      wr_ptr_r <= flush_i ? '0 : (push ? wr_ptr_r + 1'b1 : wr_ptr_r);
      rd_ptr_r <= flush_i ? '0 : (pop ? rd_ptr_r + 1'b1 : rd_ptr_r);
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  assign in_ready_o  = ready_r;
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem[rd_ptr_r];
endmodule : rpm_word_fifo

// ---------------------------------------------------------------
// operating-mode state machine
// ---------------------------------------------------------------
module rpm_receiver_power_mode_fsm
  import rpm_pkg::*;
#(
  parameter int WAKEUP_CYC = WAKEUP_CYC_DEF,
  parameter int SLEEP_CYC  = SLEEP_CYC_DEF,
  parameter int PWRDN_CYC  = PWRDN_CYC_DEF
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              receive_enable_input_i,
  input  wire logic              link_clk_i,
  input  wire logic              clock_common_mode_level_i,
  input  wire logic              pll_lock_i,
  input  wire logic              link_select_bit0_i,
  input  wire logic              link_select_bit1_i,
  input  wire logic              word_valid_i,
  output logic                   word_ready_o,
  input  wire logic [WORD_W-1:0] word_data_i,
  output logic      [PIX_W-1:0]  pixel_data_o,
  output logic                   vertical_sync_o,
  output logic                   horizontal_sync_o,
  output logic                   display_enable_o,
  output logic                   pixel_clk_o,
  output logic                   pll_enable_o,
  output logic                   monitor_enable_o,
  output logic      [2:0]        lane_enable_o,
  output logic      [1:0]        mode_o
);
  // ---------------------------------------------------------------
  // pin synchronisers, two flops each
  // ---------------------------------------------------------------
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic       link_clk_d_r;

  // enable pin stays sampled in every mode, shutdown included [R15]
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync1_r      <= '0;
      sync2_r      <= '0;
      link_clk_d_r <= 1'b0;
    end else begin
      sync1_r      <= {link_select_bit1_i, link_select_bit0_i, pll_lock_i,
                       clock_common_mode_level_i, link_clk_i, receive_enable_input_i};
      sync2_r      <= sync1_r;
      link_clk_d_r <= sync2_r[1];
    end
  end

  wire       en_pin_s  = sync2_r[0];
  wire       cm_high_s = sync2_r[2];
  wire       lock_s    = sync2_r[3];
  wire [1:0] ls_s      = sync2_r[5:4];
  wire       link_edge = sync2_r[1] & ~link_clk_d_r;

  // ---------------------------------------------------------------
  // counters: enable filter, link idle, wakeup and sleep
  // ---------------------------------------------------------------
  rpm_mode_t        state_r;
  rpm_mode_t        state_nxt;
  logic [CNT_W-1:0] en_hi_cnt_r;
  logic [CNT_W-1:0] en_lo_cnt_r;
  logic [CNT_W-1:0] idle_cnt_r;
  logic [CNT_W-1:0] wake_cnt_r;
  logic [CNT_W-1:0] sleep_cnt_r;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic run);
    sat_inc = !run ? '0 : ((&v) ? v : v + 1'b1);
  endfunction : sat_inc

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      en_hi_cnt_r <= '0;
      en_lo_cnt_r <= '0;
      idle_cnt_r  <= '0;
      wake_cnt_r  <= '0;
      sleep_cnt_r <= '0;
    end else begin
      en_hi_cnt_r <= sat_inc(en_hi_cnt_r, en_pin_s);
      en_lo_cnt_r <= sat_inc(en_lo_cnt_r, ~en_pin_s);
      idle_cnt_r  <= sat_inc(idle_cnt_r, ~link_edge);
      wake_cnt_r  <= sat_inc(wake_cnt_r, state_r == RPM_ACQUIRE);
      sleep_cnt_r <= sat_inc(sleep_cnt_r, cm_high_s);
    end
  end

  // link is live only when it toggles fast enough and its level is valid
  wire link_slow   = (idle_cnt_r >= CNT_W'(LINK_IDLE_CYC));                  // [R16]
  wire link_active = ~cm_high_s & ~link_slow;                               // [R5]
  wire sleep_req   = (sleep_cnt_r >= CNT_W'(SLEEP_CYC)) | link_slow;        // [R11] [R18]
  wire en_on       = (en_hi_cnt_r > CNT_W'(EN_FILTER_CYC));                 // [R2]
  wire off_filter  = (en_lo_cnt_r > CNT_W'(EN_FILTER_CYC));                 // [R1]
  wire off_pwrdn   = (en_lo_cnt_r > CNT_W'(PWRDN_CYC));                     // [R14] [R18]
  wire wake_late   = (wake_cnt_r >= CNT_W'(WAKEUP_CYC));                    // [R18]

  // ---------------------------------------------------------------
  // mode transitions
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RPM_SHUTDOWN: begin
        if (en_on) begin
          state_nxt = RPM_STANDBY;                                         // [R4]
        end
      end
      RPM_STANDBY: begin
        if (off_pwrdn) begin
          state_nxt = RPM_SHUTDOWN;                                        // [R14]
        end else if (en_pin_s && link_active) begin
          state_nxt = RPM_ACQUIRE;                                         // [R5]
        end
      end
      RPM_ACQUIRE: begin
        if (off_filter) begin
          state_nxt = RPM_SHUTDOWN;                                        // [R1]
        end else if (!link_active || wake_late) begin
          state_nxt = RPM_STANDBY;                                         // [R2]
        end else if (lock_s && en_pin_s) begin
          state_nxt = RPM_RECEIVE;                                         // [R7]
        end
      end
      RPM_RECEIVE: begin
        if (off_pwrdn) begin
          state_nxt = RPM_SHUTDOWN;                                        // [R14]
        end else if (sleep_req) begin
          state_nxt = RPM_STANDBY;                                         // [R11]
        end else if (!lock_s || !en_pin_s) begin
          state_nxt = RPM_ACQUIRE;                                         // [R7]
        end
      end
      default: begin
        state_nxt = RPM_SHUTDOWN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // word fifo; drained at half rate so a pixel clock can be formed
  // ---------------------------------------------------------------
  logic              fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  logic              pclk_r;
  wire               in_recv  = (state_r == RPM_RECEIVE) && (state_nxt == RPM_RECEIVE);
  wire               take     = in_recv & fifo_valid & ~pclk_r;

  rpm_word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (state_r != RPM_RECEIVE),
    .in_valid_i  (word_valid_i),
    .in_ready_o  (word_ready_o),
    .in_data_i   (word_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (take),
    .out_data_o  (fifo_data)
  );

  // ---------------------------------------------------------------
  // lane selection from link-select pins, reserved code enables none
  // ---------------------------------------------------------------
  logic [2:0] lanes_sel;

  always_comb begin
    case (ls_s)                                                            // [R17]
      LS_ONE:   lanes_sel = LANES_ONE;
      LS_TWO:   lanes_sel = LANES_TWO;
      LS_THREE: lanes_sel = LANES_THREE;
      default:  lanes_sel = LANES_NONE;
    endcase
  end

  // ---------------------------------------------------------------
  // state and output registers
  // ---------------------------------------------------------------
  logic [PIX_W-1:0] pix_r;
  logic             vsync_r;
  logic             hsync_r;
  logic             den_r;
  logic             pll_en_r;
  logic             mon_en_r;
  logic [2:0]       lanes_r;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r <= RPM_SHUTDOWN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // power controls follow the mode being entered
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pll_en_r <= 1'b0;
      mon_en_r <= 1'b0;
      lanes_r  <= LANES_NONE;
    end else begin
      pll_en_r <= (state_nxt == RPM_ACQUIRE) || (state_nxt == RPM_RECEIVE); // [R3] [R6] [R13]
      mon_en_r <= (state_nxt != RPM_SHUTDOWN);                              // [R4] [R13]
      lanes_r  <= (state_nxt == RPM_RECEIVE) ? lanes_sel : LANES_NONE;     // [R8]
    end
  end

  // outputs hold the static pattern until the first word is recovered;
  // leaving receive drops the pixel clock and restores the pattern at once
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pix_r   <= STATIC_PIX;
      vsync_r <= STATIC_SYNC;
      hsync_r <= STATIC_SYNC;
      den_r   <= STATIC_LOW;
      pclk_r  <= STATIC_LOW;
    end else if (!in_recv) begin
      pix_r   <= STATIC_PIX;                                               // [R12] [R14]
      vsync_r <= STATIC_SYNC;
      hsync_r <= STATIC_SYNC;
      den_r   <= STATIC_LOW;
      pclk_r  <= STATIC_LOW;                                               // [R12]
    end else if (take) begin
      pix_r   <= fifo_data[PIX_W-1:0];                                     // [R9]
      vsync_r <= fifo_data[VSYNC_BIT];
      hsync_r <= fifo_data[HSYNC_BIT];
      den_r   <= fifo_data[DEN_BIT];
      pclk_r  <= 1'b1;
    end else begin
      pclk_r       <= 1'b0;
    end
  end

  assign pixel_data_o      = pix_r;
  assign vertical_sync_o   = vsync_r;
  assign horizontal_sync_o = hsync_r;
  assign display_enable_o  = den_r;
  assign pixel_clk_o       = pclk_r;
  assign pll_enable_o      = pll_en_r;
  assign monitor_enable_o  = mon_en_r;
  assign lane_enable_o     = lanes_r;
  assign mode_o            = state_r;
endmodule : rpm_receiver_power_mode_fsm

// *** verification/rpm_fsm_props.sv ***
// checker: mode, enable and output relations of the receiver mode machine
`timescale 1ns/10ps
module rpm_fsm_props
  import rpm_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire logic              receive_enable_input_i,
  input wire logic              link_clk_i,
  input wire logic              clock_common_mode_level_i,
  input wire logic              pll_lock_i,
  input wire logic              link_select_bit0_i,
  input wire logic              link_select_bit1_i,
  input wire logic              word_valid_i,
  input wire logic              word_ready_o,
  input wire logic [WORD_W-1:0] word_data_i,
  input wire logic [PIX_W-1:0]  pixel_data_o,
  input wire logic              vertical_sync_o,
  input wire logic              horizontal_sync_o,
  input wire logic              display_enable_o,
  input wire logic              pixel_clk_o,
  input wire logic              pll_enable_o,
  input wire logic              monitor_enable_o,
  input wire logic [2:0]        lane_enable_o,
  input wire logic [1:0]        mode_o
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // outputs sit at the fixed pattern
  wire logic static_w = pixel_data_o == STATIC_PIX && vertical_sync_o && horizontal_sync_o
                        && !display_enable_o && !pixel_clk_o;
  property p_stat; mode_o != RPM_RECEIVE |-> static_w; endproperty
  a_stat: assert property (p_stat) else $error("outputs not static");
  property p_pll; pll_enable_o == mode_o[1]; endproperty
  a_pll: assert property (p_pll) else $error("pll enable wrong");
  property p_mon; monitor_enable_o == (mode_o != RPM_SHUTDOWN); endproperty
  a_mon: assert property (p_mon) else $error("monitor enable wrong");
  property p_lane; lane_enable_o != LANES_NONE |-> mode_o == RPM_RECEIVE; endproperty
  a_lane: assert property (p_lane) else $error("lanes on outside receive");
  property p_shut; $past(mode_o) != RPM_SHUTDOWN && mode_o == RPM_SHUTDOWN
    |-> !$past(receive_enable_input_i, 3); endproperty
  a_shut: assert property (p_shut) else $error("shutdown with enable high");
  property p_stby; $past(mode_o) == RPM_SHUTDOWN && mode_o == RPM_STANDBY
    |-> $past(receive_enable_input_i, 3); endproperty
  a_stby: assert property (p_stby) else $error("standby with enable low");
  property p_acq; $past(mode_o) == RPM_STANDBY && mode_o == RPM_ACQUIRE
    |-> $past(receive_enable_input_i, 2) && !$past(clock_common_mode_level_i, 2); endproperty
  a_acq: assert property (p_acq) else $error("wake without valid level");
  property p_rcv; $past(mode_o) == RPM_ACQUIRE && mode_o == RPM_RECEIVE
    |-> $past(pll_lock_i, 2); endproperty
  a_rcv: assert property (p_rcv) else $error("receive without lock");
  property p_sleep; $rose(clock_common_mode_level_i) && mode_o == RPM_RECEIVE
    && receive_enable_input_i |-> ##[1:10] mode_o == RPM_STANDBY; endproperty
  a_sleep: assert property (p_sleep) else $error("no standby after sleep");
  property p_pclk; pixel_clk_o |=> !pixel_clk_o; endproperty
  a_pclk: assert property (p_pclk) else $error("pixel clock too long");
  c_word: cover property (mode_o == RPM_RECEIVE && pixel_clk_o);
  c_full: cover property (mode_o == RPM_RECEIVE && !word_ready_o);
  c_back: cover property ($past(mode_o) == RPM_RECEIVE && mode_o == RPM_STANDBY);
  c_wake: cover property ($past(mode_o) == RPM_ACQUIRE && mode_o == RPM_STANDBY);
endmodule : rpm_fsm_props

bind rpm_receiver_power_mode_fsm rpm_fsm_props u_props (.*);

// *** verification/rpm_tx_model.sv ***
// transmitter model: link clock and clock common-mode level
`timescale 1ns/10ps
module rpm_tx_model (
  input  wire logic run_i,
  input  wire logic slow_i,
  output logic      link_clk_o,
  output logic      cm_high_o
);
  // ---------------------------------------------------------------
  // line drive
  // ---------------------------------------------------------------
  // driver off floats the common mode up to the pull-up
  assign cm_high_o = !run_i;
  // clock toggles only while driving; stands low when stopped or slowed
  always begin
    link_clk_o = 1'b0;
    wait (run_i === 1'b1 && slow_i === 1'b0);
    #1013;
    while (run_i === 1'b1 && slow_i === 1'b0) begin
      #200;
      if (run_i === 1'b1 && slow_i === 1'b0) link_clk_o = !link_clk_o;
    end
  end
endmodule : rpm_tx_model

// *** verification/rpm_receiver_power_mode_fsm_tb_top.sv ***
// testbench: mode sequencing and word path of the receiver mode machine
`timescale 1ns/10ps
module rpm_receiver_power_mode_fsm_tb_top;
  import rpm_pkg::*;
  // ---------------------------------------------------------------
  // signals, clock, instances
  // ---------------------------------------------------------------
  logic              clk = 1'b0, rst_b = 1'b0, en = 1'b0, run = 1'b0, slow = 1'b0;
  logic              lock = 1'b0, sel0 = 1'b0, sel1 = 1'b0, wv = 1'b0, saw_full;
  logic [WORD_W-1:0] wd = '0;
  logic [WORD_W-1:0] got_q[$];
  wire logic         link_clk, cm, wr, vsy, hsy, den, pclk, plle, mone;
  wire logic [PIX_W-1:0] pix;
  wire logic [2:0]   lanes;
  wire logic [1:0]   mode;
  int                n_mismatch = 0;
  int                total_checks = 0;
  always #25 clk = !clk;
  rpm_receiver_power_mode_fsm #(.WAKEUP_CYC(20), .SLEEP_CYC(2), .PWRDN_CYC(10)) dut_u (
    .clk_i(clk), .rst_b_i(rst_b), .receive_enable_input_i(en), .link_clk_i(link_clk),
    .clock_common_mode_level_i(cm), .pll_lock_i(lock), .link_select_bit0_i(sel0),
    .link_select_bit1_i(sel1), .word_valid_i(wv), .word_ready_o(wr), .word_data_i(wd),
    .pixel_data_o(pix), .vertical_sync_o(vsy), .horizontal_sync_o(hsy),
    .display_enable_o(den), .pixel_clk_o(pclk), .pll_enable_o(plle),
    .monitor_enable_o(mone), .lane_enable_o(lanes), .mode_o(mode));
  rpm_tx_model tx_u (.run_i(run), .slow_i(slow), .link_clk_o(link_clk), .cm_high_o(cm));
  // collect each word shown with the pixel clock pulse
  always @(negedge clk) if (pclk === 1'b1) got_q.push_back({vsy, hsy, den, pix});
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic wait_mode(input logic [1:0] m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (mode !== m) begin
      chk("mode wait", mode, m);
      stop_test();
    end
  endtask : wait_mode
  task automatic push(input logic [WORD_W-1:0] w);
    int n;
    n = 0;
    wd = w;
    wv = 1'b1;
    while (wr !== 1'b1 && n < 40) begin
      saw_full = 1'b1;
      @(negedge clk);
      n++;
    end
    if (wr !== 1'b1) begin
      chk("ready wait", wr, 1);
      stop_test();
    end
    @(negedge clk);
  endtask : push
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_enable;
    en = 1'b1;
    repeat (195) @(negedge clk);
    chk("filter mode", mode, RPM_SHUTDOWN);
    wait_mode(RPM_STANDBY, 60);
    chk("monitor", mone, 1);
    chk("pll off", plle, 0);
    $display("test enable done");
  endtask : t_enable
  task automatic t_link(input int i);
    logic [2:0] tab[3] = '{LANES_ONE, LANES_TWO, LANES_THREE};
    {sel1, sel0} = 2'(i);
    run = 1'b1;
    got_q.delete();
    saw_full = 1'b0;
    wait_mode(RPM_ACQUIRE, 100);
    chk("acq pll", plle, 1);
    repeat (5) @(negedge clk);
    lock = 1'b1;
    wait_mode(RPM_RECEIVE, 20);
    chk("lanes", lanes, tab[i]);
    chk("pre word", pix, STATIC_PIX);
    for (int k = 0; k < 8; k++) push(27'h2a5a5a0 + 27'(k));
    wv = 1'b0;
    for (int n = 0; n < 40 && got_q.size() < 8; n++) @(negedge clk);
    chk("word count", got_q.size(), 8);
    for (int k = 0; k < got_q.size(); k++) chk("word", got_q[k], 27'h2a5a5a0 + 27'(k));
    chk("refused", saw_full, 1);
    lock = 1'b0;
    wait_mode(RPM_ACQUIRE, 20);
    lock = 1'b1;
    wait_mode(RPM_RECEIVE, 20);
    run = 1'b0;
    wait_mode(RPM_STANDBY, 12);
    chk("sleep pix", pix, STATIC_PIX);
    chk("sleep pll", plle, 0);
    chk("sleep mon", mone, 1);
    lock = 1'b0;
    $display("test link %0d done", i);
  endtask : t_link
  task automatic t_slow;
    run = 1'b1;
    wait_mode(RPM_ACQUIRE, 100);
    // no lock: acquire gives up after the wakeup count and retries
    wait_mode(RPM_STANDBY, 30);
    chk("wake timeout pll", plle, 0);
    wait_mode(RPM_ACQUIRE, 5);
    lock = 1'b1;
    wait_mode(RPM_RECEIVE, 20);
    slow = 1'b1;
    wait_mode(RPM_STANDBY, 80);
    chk("slow lanes", lanes, LANES_NONE);
    run = 1'b0;
    slow = 1'b0;
    lock = 1'b0;
    repeat (20) @(negedge clk);
    chk("slow mode", mode, RPM_STANDBY);
    $display("test slow done");
  endtask : t_slow
  task automatic t_shutdown;
    en = 1'b0;
    repeat (4) @(negedge clk);
    en = 1'b1;
    repeat (30) @(negedge clk);
    chk("glitch", mode, RPM_STANDBY);
    en = 1'b0;
    wait_mode(RPM_SHUTDOWN, 40);
    chk("shut mon", mone, 0);
    en = 1'b1;
    wait_mode(RPM_STANDBY, 250);
    $display("test shutdown done");
  endtask : t_shutdown
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    t_enable();
    for (int i = 0; i < 3; i++) t_link(i);
    t_slow();
    t_shutdown();
    stop_test();
  end
endmodule : rpm_receiver_power_mode_fsm_tb_top
